/* hw/tlc_pkg.sv */
package tlc_pkg;

   // ==========================================================
   // Register indices (byte address = index * 4)
   localparam logic [7:0] IDX_COLL_POS   = 8'h20;
   localparam logic [7:0] IDX_TGT_STATE  = 8'h21;
   localparam logic [7:0] IDX_TXLEN_HI   = 8'h22;
   localparam logic [7:0] IDX_TXLEN_LO   = 8'h23;
   localparam logic [7:0] IDX_CTRL       = 8'h30;
   localparam logic [7:0] IDX_IRQ_STAT   = 8'h31;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h32;

   // ==========================================================
   // Field positions and reset values
   localparam int         TXLO_BITS_LSB  = 0;
   localparam int         TXLO_BYTES_LSB = 3;
   localparam int         CTRL_ANCTL_BIT = 0;
   localparam logic [7:0] TXLEN_RST      = 8'h00;
   localparam logic [7:0] CTRL_RST       = 8'h00;
   localparam logic [2:0] IRQ_RST        = 3'h0;

   // Interrupt status bits
   localparam int IRQ_N       = 3;
   localparam int IRQ_COLL    = 0;
   localparam int IRQ_PAR     = 1;
   localparam int IRQ_ACTIVE  = 2;

   // ==========================================================
   // Passive target state codes
   localparam logic [3:0] PT_POWER_OFF  = 4'h0;
   localparam logic [3:0] PT_IDLE       = 4'h1;
   localparam logic [3:0] PT_READY_L1   = 4'h2;
   localparam logic [3:0] PT_READY_L2   = 4'h3;
   localparam logic [3:0] PT_RSVD_A     = 4'h4;
   localparam logic [3:0] PT_ACTIVE     = 4'h5;
   localparam logic [3:0] PT_READY_L2S  = 4'hB;
   localparam logic [3:0] PT_RSVD_B     = 4'hC;
   localparam logic [3:0] PT_ACTIVE_S   = 4'hD;

   // ==========================================================
   // Protocol modes and direct commands
   typedef enum logic [1:0] {
      TLC_PROTO_A,
      TLC_PROTO_B,
      TLC_PROTO_OTHER
   } tlc_proto_t;

   typedef enum logic [1:0] {
      TLC_CMD_REQA,
      TLC_CMD_WUPA,
      TLC_CMD_TX_NOCRC,
      TLC_CMD_TX_CRC
   } tlc_cmd_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       done;      // End of reception strobe
      logic       anticoll;  // Frame was an anticollision command
      logic       collided;  // A collision was seen
      logic [3:0] nbytes;    // Full bytes before collision
      logic [2:0] nbits;     // Bits before collision
      logic       in_parity; // First collision in a parity bit
   } tlc_rx_rep_t;

   typedef struct packed {
      logic     valid;
      tlc_cmd_t cmd;
   } tlc_cmd_req_t;

   typedef struct packed {
      logic        start;       // One-cycle start of a transmission
      logic [12:0] nbytes;      // Full bytes
      logic [2:0]  nbits;       // Trailing bits, LSB first
      logic [7:0]  last_mask;   // Valid bits of the partial byte
      logic        no_parity;   // Partial byte sent without parity
   } tlc_tx_job_t;

endpackage

/* hw/tlc_sticky.sv */
`timescale 1ns/1ns
module tlc_sticky
   import tlc_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Events and write-one-to-clear
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] clr_i,
   // State
   output logic      [W-1:0] flag_q
);

   // Set beats clear so a same-cycle event is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= '0;
      end else begin
         flag_q <= set_i | (flag_q & ~clr_i);
      end
   end

endmodule

/* hw/tlc_regs.sv */
// Functional notes
// - After an anticollision reception with a collision, bits 7:4 hold the full byte count.
// - Bits 3:1 hold the number of bits of the colliding byte received before the collision.
// - Bit 0 is set when the first collision is in a parity bit and cleared without collision.
// - Only anticollision frames update the collision position; longer messages leave it.
// - The passive target state is shown as a 4-bit code with two reserved codes.
// - In the active or active-star state automatic answers stop and software handles all.
// - The 13-bit byte count is split as 8 high bits and 5 low bits in bits 7:3.
// - Bits 2:0 of the low length register give the trailing bits; zero means full bytes.
// - Trailing bits are sent starting from the least significant bit.
// - An ISO-A split-byte anticollision frame sends its partial byte without parity.
// - REQA or WUPA with anticollision set, card idle and trailing bits raises parity error.
// - Short frames go out only for ISO-A or ISO-B under the transmit-without-CRC command.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module tlc_regs
   import tlc_pkg::*;
(
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // APB slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [9:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // Receive framer report
   input  wire tlc_rx_rep_t  rx_rep,
   // Passive target machine
   input  wire logic [3:0]   pt_state,
   output logic              pt_auto_answer,
   // Direct command and protocol
   input  wire tlc_cmd_req_t cmd_req,
   input  wire tlc_proto_t   proto,
   output tlc_tx_job_t       tx_job,
   // Events
   output logic              par_err_pulse,
   output logic              irq
);

   // ==========================================================
   // Storage
   logic [7:0]       coll_pos_q;
   logic [3:0]       pt_state_q;
   logic [7:0]       txlen_hi_q;
   logic [7:0]       txlen_lo_q;
   logic [7:0]       ctrl_q;
   logic [IRQ_N-1:0] irq_mask_q;
   logic [IRQ_N-1:0] irq_stat;
   logic [IRQ_N-1:0] irq_set;
   logic [IRQ_N-1:0] irq_clr;
   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;
   logic             irq_q;
   logic             par_err_q;
   logic             auto_q;
   tlc_tx_job_t      tx_job_q;

   // ==========================================================
   // APB decode
   logic [7:0] idx;
   logic       aligned;
   logic       setup;
   logic       wr_en;
   logic       mapped;
   logic [7:0] wbyte;

   assign idx     = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign setup   = psel && !penable && !pready_q;
   assign wr_en   = psel && penable && pready_q && pwrite && !pslverr_q;
   assign wbyte   = pwdata[7:0];

   always_comb begin
      unique case (idx)
         IDX_COLL_POS, IDX_TGT_STATE, IDX_TXLEN_HI, IDX_TXLEN_LO,
         IDX_CTRL, IDX_IRQ_STAT, IDX_IRQ_MASK: mapped = aligned;
         default:                               mapped = 1'b0;
      endcase
   end

   logic [7:0] rd_val;
   always_comb begin
      rd_val = 8'h00;
      unique case (idx)
         IDX_COLL_POS:  rd_val = coll_pos_q;
         IDX_TGT_STATE: rd_val = {4'h0, pt_state_q};
         IDX_TXLEN_HI:  rd_val = txlen_hi_q;
         IDX_TXLEN_LO:  rd_val = txlen_lo_q;
         IDX_CTRL:      rd_val = ctrl_q;
         IDX_IRQ_STAT:  rd_val = {5'h00, irq_stat};
         IDX_IRQ_MASK:  rd_val = {5'h00, irq_mask_q};
         default:       rd_val = 8'h00;
      endcase
   end

   // ==========================================================
   // Bus answer: no wait state, data with pready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !mapped;
         if (setup) begin
            prdata_q <= (mapped && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // Writable registers; read-only ones take no write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txlen_hi_q <= TXLEN_RST;
         txlen_lo_q <= TXLEN_RST;
         ctrl_q     <= CTRL_RST;
         irq_mask_q <= IRQ_RST;
      end else if (wr_en) begin
         unique case (idx)
            IDX_TXLEN_HI: txlen_hi_q <= wbyte;
            IDX_TXLEN_LO: txlen_lo_q <= wbyte;
            IDX_CTRL:     ctrl_q     <= {7'h00, wbyte[CTRL_ANCTL_BIT]};
            IDX_IRQ_MASK: irq_mask_q <= wbyte[IRQ_N-1:0];
            default:      ctrl_q     <= ctrl_q;
         endcase
      end
   end

   // ==========================================================
   // Collision capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coll_pos_q <= 8'h00;
      end else if (rx_rep.done && rx_rep.anticoll) begin
         if (rx_rep.collided) begin
            coll_pos_q <= {rx_rep.nbytes, rx_rep.nbits, rx_rep.in_parity};
         end else begin
            coll_pos_q <= 8'h00;
         end
      end
   end

   // ==========================================================
   // Passive target state view and automatic answer gate
   logic pt_is_active;
   assign pt_is_active = (pt_state == PT_ACTIVE) || (pt_state == PT_ACTIVE_S);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pt_state_q <= PT_POWER_OFF;
         auto_q     <= 1'b0;
      end else begin
         pt_state_q <= pt_state;
         auto_q     <= !pt_is_active && (pt_state != PT_POWER_OFF);
      end
   end

   // ==========================================================
   // Transmit job
   logic [2:0] nbtx;
   logic       short_ok;
   logic       is_reqwup;
   assign nbtx      = txlen_lo_q[TXLO_BITS_LSB +: 3];
   assign is_reqwup = (cmd_req.cmd == TLC_CMD_REQA) || (cmd_req.cmd == TLC_CMD_WUPA);
   // Other protocols or commands fall back to full bytes only
   assign short_ok  = (proto != TLC_PROTO_OTHER) && (cmd_req.cmd == TLC_CMD_TX_NOCRC);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_job_q <= '0;
      end else begin
         tx_job_q.start <= cmd_req.valid && !is_reqwup;
         if (cmd_req.valid && !is_reqwup) begin
            tx_job_q.nbytes    <= {txlen_hi_q, txlen_lo_q[TXLO_BYTES_LSB +: 5]};
            tx_job_q.nbits     <= short_ok ? nbtx : 3'h0;
            tx_job_q.last_mask <= short_ok ? 8'((9'h001 << nbtx) - 9'h001) : 8'h00;
            tx_job_q.no_parity <= short_ok && (proto == TLC_PROTO_A) && (nbtx != 3'h0);
         end
      end
   end

   // ==========================================================
   // Parity error on a forbidden split-byte REQA or WUPA
   logic par_evt;
   assign par_evt = cmd_req.valid && is_reqwup && ctrl_q[CTRL_ANCTL_BIT] &&
                    (pt_state_q == PT_IDLE) && (nbtx != 3'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_err_q <= 1'b0;
      end else begin
         par_err_q <= par_evt;
      end
   end

   // ==========================================================
   // Interrupt status, write one to clear
   logic act_prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_prev_q <= 1'b0;
      end else begin
         act_prev_q <= pt_is_active;
      end
   end

   always_comb begin
      irq_set             = '0;
      irq_set[IRQ_COLL]   = rx_rep.done && rx_rep.anticoll && rx_rep.collided;
      irq_set[IRQ_PAR]    = par_evt;
      irq_set[IRQ_ACTIVE] = pt_is_active && !act_prev_q;
      irq_clr             = (wr_en && idx == IDX_IRQ_STAT) ? wbyte[IRQ_N-1:0] : '0;
   end

   tlc_sticky #(.W(IRQ_N)) u_irq_stat (
      .pclk    (pclk),
      .presetn (presetn),
      .set_i   (irq_set),
      .clr_i   (irq_clr),
      .flag_q  (irq_stat)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |((irq_set | (irq_stat & ~irq_clr)) & irq_mask_q);
      end
   end

   // ==========================================================
   // Outputs
   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign tx_job         = tx_job_q;
   assign par_err_pulse  = par_err_q;
   assign pt_auto_answer = auto_q;
   assign irq            = irq_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   coll_capture_a: assert property (
      rx_rep.done && rx_rep.anticoll && rx_rep.collided
      |=> coll_pos_q[7:4] == $past(rx_rep.nbytes) && coll_pos_q[3:1] == $past(rx_rep.nbits))
      else $error("collision byte or bit count not captured");

   parity_flag_a: assert property (
      rx_rep.done && rx_rep.anticoll
      |=> coll_pos_q[0] == $past(rx_rep.collided && rx_rep.in_parity))
      else $error("parity collision flag wrong");

   long_msg_a: assert property (
      rx_rep.done && !rx_rep.anticoll && !wr_en |=> $stable(coll_pos_q))
      else $error("collision position changed by a long message");

   state_view_a: assert property (
      ##1 pt_state_q == $past(pt_state))
      else $error("target state view lags wrongly");

   no_auto_a: assert property (
      pt_is_active |=> !pt_auto_answer)
      else $error("automatic answer while active");

   byte_count_a: assert property (
      cmd_req.valid && !is_reqwup
      |=> tx_job.start && tx_job.nbytes == {$past(txlen_hi_q), $past(txlen_lo_q[7:3])})
      else $error("transmit byte count mismatch");

   split_parity_a: assert property (
      cmd_req.valid && cmd_req.cmd == TLC_CMD_TX_NOCRC && proto == TLC_PROTO_A && nbtx != 3'h0
      |=> tx_job.no_parity && tx_job.nbits == $past(nbtx))
      else $error("split byte sent with parity");

   short_gate_a: assert property (
      cmd_req.valid && !is_reqwup && !short_ok |=> tx_job.nbits == 3'h0)
      else $error("short frame outside its command");

   par_irq_a: assert property (
      par_evt && irq_mask_q[IRQ_PAR] |=> par_err_pulse && irq && irq_stat[IRQ_PAR])
      else $error("parity error interrupt missing");

   ro_write_a: assert property (
      wr_en && idx == IDX_COLL_POS && !(rx_rep.done && rx_rep.anticoll)
      |=> $stable(coll_pos_q))
      else $error("read-only collision register took a write");

   rsvd_zero_a: assert property (
      pready && !pwrite && idx == IDX_TGT_STATE |-> prdata[7:4] == 4'h0)
      else $error("reserved target bits not zero");

   coll_clear_a: assert property (
      rx_rep.done && rx_rep.anticoll && !rx_rep.collided |=> coll_pos_q == 8'h00)
      else $error("collision register not cleared");

   coll_irq_a: assert property (
      rx_rep.done && rx_rep.anticoll && rx_rep.collided |=> irq_stat[IRQ_COLL])
      else $error("collision status bit not set");

   auto_on_a: assert property (
      !pt_is_active && pt_state != PT_POWER_OFF |=> pt_auto_answer)
      else $error("automatic answer missing before active");

   trail_mask_a: assert property (
      tx_job.start |-> $countones(tx_job.last_mask) == tx_job.nbits &&
                       (tx_job.last_mask & (tx_job.last_mask + 8'h01)) == 8'h00)
      else $error("partial byte mask not packed from bit 0");

   trail_bits_a: assert property (
      cmd_req.valid && short_ok |=> tx_job.nbits == $past(nbtx))
      else $error("trailing bit count not passed on");

   par_quiet_a: assert property (
      !(cmd_req.valid && is_reqwup) |=> !par_err_pulse)
      else $error("parity error without its command");

   slverr_a: assert property (
      setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   irq_level_a: assert property (
      ##1 irq == |(irq_stat & $past(irq_mask_q)))
      else $error("interrupt level wrong");

   apb_answer_a: assert property (
      setup |=> pready ##1 !pready)
      else $error("bus answer timing wrong");

   cov_coll_c:   cover property (rx_rep.done && rx_rep.anticoll && rx_rep.collided);
   cov_par_c:    cover property (par_evt ##1 irq);
   cov_active_c: cover property (pt_is_active ##1 !pt_auto_answer);
   cov_split_c:  cover property (tx_job.start && tx_job.no_parity);
   cov_clear_c:  cover property (rx_rep.done && rx_rep.anticoll && !rx_rep.collided);

endmodule

/* test/tlc_host.sv */
`timescale 1ns/1ns
module tlc_host
   import tlc_pkg::*;
(
   // Clock
   input  wire logic        pclk,
   // APB master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [9:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Receive status
   input  wire logic        receive_error_flag
);
   // ==========================================
   // Collision fields usable only without a receive error
   logic coll_ok;
   assign coll_ok = !receive_error_flag;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // ==========================================
   // One transfer; no latency assumed, the bench timeout ends a hang
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show no stale value
      pwdata <= ~{24'h000000, wd};
      paddr <= ~{idx, 2'b00};
   endtask

   // Thirteen-bit argument keeps the count within range
   task automatic set_len(input logic [12:0] n, input logic [2:0] b);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, IDX_TXLEN_HI, n[12:5], rd, err);
      xfer(1'b1, IDX_TXLEN_LO, {n[4:0], b}, rd, err);
   endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top
   import tlc_pkg::*;
;
   logic         pclk = 1'b0;
   logic         presetn;
   logic         psel, penable, pwrite, pready, pslverr, irq;
   logic [9:0]   paddr;
   logic [31:0]  pwdata, prdata, rdat;
   logic         rerr, pt_auto_answer, par_err_pulse, rx_err;
   tlc_rx_rep_t  rx_rep;
   logic [3:0]   pt_state;
   tlc_cmd_req_t cmd_req;
   tlc_proto_t   proto;
   tlc_tx_job_t  tx_job, job;
   int           failures = 0;
   int           total_checks = 0;
   int           cycles = 0;
   int           starts, pars;
   logic         short_f;
   logic [3:0]   codes [9] = '{PT_POWER_OFF, PT_IDLE, PT_READY_L1, PT_READY_L2, PT_RSVD_A,
                               PT_ACTIVE, PT_READY_L2S, PT_RSVD_B, PT_ACTIVE_S};

   always #2 pclk = ~pclk;

   tlc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_rep(rx_rep), .pt_state(pt_state),
      .pt_auto_answer(pt_auto_answer), .cmd_req(cmd_req), .proto(proto), .tx_job(tx_job),
      .par_err_pulse(par_err_pulse), .irq(irq));

   tlc_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .receive_error_flag(rx_err));

   // ==========================================
   // Helpers
   task automatic conclude();
      if (failures == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      host.xfer(1'b1, idx, d, rdat, rerr);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      host.xfer(1'b0, idx, 8'h00, rdat, rerr);
      chk(rdat, exp);
   endtask

   task automatic rx(input logic ac, col, input logic [3:0] nb, input logic [2:0] nt,
                     input logic p);
      @(posedge pclk);
      rx_rep <= '{1'b1, ac, col, nb, nt, p};
      @(posedge pclk);
      rx_rep <= '0;
   endtask

   // Counts pulses over three cycles, so a missing or doubled pulse shows
   task automatic send_cmd(input tlc_cmd_t c);
      starts = 0;
      pars = 0;
      job = '0;
      @(posedge pclk);
      cmd_req <= '{1'b1, c};
      @(posedge pclk);
      cmd_req <= '0;
      repeat (3) begin
         @(negedge pclk);
         if (tx_job.start === 1'b1) begin
            starts++;
            job = tx_job;
         end
         if (par_err_pulse === 1'b1) pars++;
      end
   endtask

   // ==========================================
   // Scenarios
   task automatic t_regs();
      for (int i = 0; i < 4; i++) rd_chk(IDX_COLL_POS + i[7:0], 32'h0);
      wr(IDX_COLL_POS, 8'hFF);
      wr(IDX_TGT_STATE, 8'hFF);
      rd_chk(IDX_COLL_POS, 32'h0);
      rd_chk(IDX_TGT_STATE, 32'h0);
      host.xfer(1'b0, 8'h40, 8'h00, rdat, rerr);
      chk(rerr, 1'b1);
      chk(irq, 1'b0);
   endtask

   task automatic t_coll();
      rx(1'b1, 1'b1, 4'h5, 3'h3, 1'b1);
      rd_chk(IDX_COLL_POS, 32'h57);
      rx_err <= 1'b1;
      @(posedge pclk);
      chk(host.coll_ok, 1'b0);
      rx_err <= 1'b0;
      rd_chk(IDX_IRQ_STAT, 32'h1);
      chk(irq, 1'b0);
      wr(IDX_IRQ_MASK, 8'h01);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      wr(IDX_IRQ_STAT, 8'h01);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      rx(1'b0, 1'b1, 4'hA, 3'h6, 1'b0);
      rd_chk(IDX_COLL_POS, 32'h57);
      rx(1'b1, 1'b1, 4'hF, 3'h7, 1'b0);
      rd_chk(IDX_COLL_POS, 32'hFE);
      rx(1'b1, 1'b0, 4'h3, 3'h2, 1'b1);
      rd_chk(IDX_COLL_POS, 32'h0);
      wr(IDX_IRQ_MASK, 8'h00);
      wr(IDX_IRQ_STAT, 8'h07);
   endtask

   task automatic t_state();
      foreach (codes[i]) begin
         @(posedge pclk);
         pt_state <= codes[i];
         repeat (3) @(posedge pclk);
         rd_chk(IDX_TGT_STATE, {28'h0, codes[i]});
         chk(pt_auto_answer, !(codes[i] inside {PT_POWER_OFF, PT_ACTIVE, PT_ACTIVE_S}));
      end
      rd_chk(IDX_IRQ_STAT, 32'h4);
      @(posedge pclk);
      pt_state <= PT_IDLE;
      wr(IDX_IRQ_STAT, 8'h07);
   endtask

   task automatic t_tx();
      host.set_len(13'd8191, 3'd3);
      rd_chk(IDX_TXLEN_HI, 32'hFF);
      rd_chk(IDX_TXLEN_LO, 32'hFB);
      for (int p = 0; p < 3; p++) begin
         for (int c = 2; c < 4; c++) begin
            short_f = (c == 2) && (p != 2);
            @(posedge pclk);
            proto <= tlc_proto_t'(p);
            send_cmd(tlc_cmd_t'(c));
            chk(starts, 1);
            chk(job.nbytes, 13'd8191);
            chk(job.nbits, short_f ? 3'd3 : 3'd0);
            chk(job.last_mask, short_f ? 8'h07 : 8'h00);
            chk(job.no_parity, short_f && p == 0);
         end
      end
      @(posedge pclk);
      proto <= TLC_PROTO_A;
      host.set_len(13'd1, 3'd0);
      send_cmd(TLC_CMD_TX_NOCRC);
      chk({job.nbytes, job.nbits, job.last_mask}, {13'd1, 3'd0, 8'h00});
   endtask

   task automatic t_par();
      wr(IDX_CTRL, 8'h01);
      wr(IDX_IRQ_MASK, 8'h02);
      host.set_len(13'd2, 3'd5);
      for (int c = 0; c < 2; c++) begin
         send_cmd(tlc_cmd_t'(c));
         chk(pars, 1);
         chk(starts, 0);
      end
      chk(irq, 1'b1);
      rd_chk(IDX_IRQ_STAT, 32'h2);
      host.set_len(13'd2, 3'd0);
      send_cmd(TLC_CMD_REQA);
      chk(pars, 0);
      host.set_len(13'd2, 3'd5);
      wr(IDX_CTRL, 8'h00);
      send_cmd(TLC_CMD_WUPA);
      chk(pars, 0);
      wr(IDX_CTRL, 8'h01);
      @(posedge pclk);
      pt_state <= PT_READY_L1;
      repeat (3) @(posedge pclk);
      send_cmd(TLC_CMD_REQA);
      chk(pars, 0);
   endtask

   // ==========================================
   // Timeout well above the few hundred cycles needed
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   initial begin
      presetn = 1'b0;
      rx_rep = '0;
      pt_state = 4'h0;
      cmd_req = '0;
      proto = TLC_PROTO_A;
      rx_err = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_coll();
      t_state();
      t_tx();
      t_par();
      conclude();
   end
endmodule
